// >>> aad_pkg.sv
// shared constants and types of the add and accumulator datapath
package aad_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int DW = 8;
  localparam int IW = 14;
  localparam int FAW = 7;
  localparam int NIB = 4;
  localparam int WBAW = 8;
  localparam int WBDW = 32;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [WBAW-1:0] OFS_INSTR = 8'h00;
  localparam logic [WBAW-1:0] OFS_ACC = 8'h04;
  localparam logic [WBAW-1:0] OFS_STATUS = 8'h08;
  localparam logic [WBAW-1:0] OFS_FADDR = 8'h0c;
  localparam logic [WBAW-1:0] OFS_FDATA = 8'h10;

  // ------------------------------------------------------------
  // status fields and reset values
  // ------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_BUSY = 8;
  localparam int ST_UNSUP = 9;
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [IW-1:0] INSTR_RST = 14'h0000;
  localparam logic [FAW-1:0] FADDR_RST = 7'h00;

  // ------------------------------------------------------------
  // opcode fields
  // ------------------------------------------------------------
  localparam int DEST_BIT = 7;
  localparam logic [4:0] OPC_ADDL = 5'h1f;
  localparam logic [5:0] OPC_ANDL = 6'h39;
  localparam logic [5:0] OPC_ADDR = 6'h07;
  localparam logic [5:0] OPC_ANDR = 6'h05;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {OP_NOP, OP_ADDL, OP_ANDL, OP_ADDR, OP_ANDR} aad_op_e;
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} aad_phase_e;

  typedef struct packed {
    aad_op_e op;
    logic toReg;
    logic [FAW-1:0] fAddr;
    logic [DW-1:0] lit;
  } aad_instr_s;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } aad_flags_s;

endpackage

// >>> aad_qphase.sv
// quarter-phase sequencer of one instruction cycle
module aad_qphase #(
  parameter int QDIV = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  output aad_pkg::aad_phase_e phase,
  output logic qTick
);

  // ------------------------------------------------------------
  // quarter length divider
  // ------------------------------------------------------------
  localparam int CW = (QDIV > 1) ? $clog2(QDIV) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(QDIV - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  generate
    if (QDIV < 1)
    begin : g_bad
      $error("QDIV must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt;
  aad_pkg::aad_phase_e next_phase;

  // qTick marks the last clock of each quarter
  assign qTick = (phase != aad_pkg::PH_IDLE) && (cnt == CNT_LAST);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if (phase == aad_pkg::PH_IDLE || qTick)
      cnt <= '0;
    else
      cnt <= cnt + CNT_ONE;
  end

  // ------------------------------------------------------------
  // phase state machine
  // ------------------------------------------------------------
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      aad_pkg::PH_IDLE: if (start) next_phase = aad_pkg::PH_Q1;
      aad_pkg::PH_Q1: if (qTick) next_phase = aad_pkg::PH_Q2;
      aad_pkg::PH_Q2: if (qTick) next_phase = aad_pkg::PH_Q3;
      aad_pkg::PH_Q3: if (qTick) next_phase = aad_pkg::PH_Q4;
      aad_pkg::PH_Q4: if (qTick) next_phase = aad_pkg::PH_IDLE;
      default: next_phase = aad_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase <= aad_pkg::PH_IDLE;
    else
      phase <= next_phase;
  end

endmodule

// >>> aad_alu.sv
// add and and unit with flag generation
module aad_alu (
  input aad_pkg::aad_op_e op,
  input wire logic [aad_pkg::DW-1:0] acc,
  input wire logic [aad_pkg::DW-1:0] operand,
  output logic [aad_pkg::DW-1:0] result,
  output aad_pkg::aad_flags_s flags,
  output logic updCarry,
  output logic updZero
);

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  logic [aad_pkg::DW:0] sum;
  logic [aad_pkg::NIB:0] lowSum;
  logic isAdd;
  logic isAnd;

  assign sum = {1'b0, acc} + {1'b0, operand};
  // digit carry is the carry out of the low nibble
  assign lowSum = {1'b0, acc[aad_pkg::NIB-1:0]} + {1'b0, operand[aad_pkg::NIB-1:0]};
  assign isAdd = (op == aad_pkg::OP_ADDL) || (op == aad_pkg::OP_ADDR);
  assign isAnd = (op == aad_pkg::OP_ANDL) || (op == aad_pkg::OP_ANDR);

  assign result = isAdd ? sum[aad_pkg::DW-1:0] : (acc & operand);
  assign flags.c = sum[aad_pkg::DW];
  assign flags.dc = lowSum[aad_pkg::NIB];
  assign flags.z = (result == '0);
  assign updCarry = isAdd;
  assign updZero = isAdd || isAnd;

endmodule

// >>> aad_datapath.sv
// add and accumulator datapath with wishbone register access
// ------------------------------------------------------------
// Overview of operation
// - add_literal_op (top bits 11 111x) adds the 8-bit literal to the accumulator, stores it there and updates c, digit_carry_flag and z.
// - add_register_op (00 0111, dest bit, 7-bit address) adds accumulator and file register and updates c, digit_carry_flag and z.
// - register forms store the result in the accumulator when the dest bit is 0 and back in the file register when it is 1.
// - and_register_op (00 0101) ands accumulator and file register into the chosen destination and updates only z.
// - literal forms decode in q1, take the literal in q2, compute in q3 and write the accumulator in q4.
// - register forms decode in q1, read the file register in q2, compute in q3 and write the destination in q4.
// ------------------------------------------------------------
//
// Our own choices: the address map and the Wishbone register port.
module aad_datapath #(
  parameter int QDIV = 1,
  parameter int FDEPTH = 128
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [aad_pkg::WBAW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [aad_pkg::WBDW-1:0] wb_dat_i,
  output logic [aad_pkg::WBDW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy,
  output logic done
);

  generate
    if (FDEPTH < 1 || FDEPTH > (1 << aad_pkg::FAW))
    begin : g_bad
      $error("FDEPTH must lie between 1 and 128");
    end
  endgenerate

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [aad_pkg::DW-1:0] acc;
  logic [aad_pkg::DW-1:0] fileMem [FDEPTH];
  logic [aad_pkg::IW-1:0] instrReg;
  logic [aad_pkg::FAW-1:0] fAddrReg;
  aad_pkg::aad_flags_s flags;
  aad_pkg::aad_instr_s dec;
  logic unsup;
  logic [aad_pkg::DW-1:0] operand;
  logic [aad_pkg::DW-1:0] result;
  aad_pkg::aad_flags_s resFlags;
  logic resUpdCarry;
  logic resUpdZero;
  logic ackReg;
  logic [aad_pkg::WBDW-1:0] datReg;

  // ------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------
  logic wbAct;
  logic wbWr;
  logic selInstr;
  logic selAcc;
  logic selStatus;
  logic selFAddr;
  logic selFData;
  logic instrWr;
  logic accWr;
  logic statusWr;
  logic fAddrWr;
  logic fDataWr;
  logic [aad_pkg::IW-1:0] instrWord;
  logic [aad_pkg::WBDW-1:0] statusWord;
  logic [aad_pkg::WBDW-1:0] rdData;
  logic [aad_pkg::DW-1:0] fileRd;

  assign wbAct = wb_cyc_i && wb_stb_i;
  // a write lands at the edge where ack is seen high
  assign wbWr = wbAct && wb_we_i && ackReg;
  assign selInstr = wb_adr_i[aad_pkg::WBAW-1:2] == aad_pkg::OFS_INSTR[aad_pkg::WBAW-1:2];
  assign selAcc = wb_adr_i[aad_pkg::WBAW-1:2] == aad_pkg::OFS_ACC[aad_pkg::WBAW-1:2];
  assign selStatus = wb_adr_i[aad_pkg::WBAW-1:2] == aad_pkg::OFS_STATUS[aad_pkg::WBAW-1:2];
  assign selFAddr = wb_adr_i[aad_pkg::WBAW-1:2] == aad_pkg::OFS_FADDR[aad_pkg::WBAW-1:2];
  assign selFData = wb_adr_i[aad_pkg::WBAW-1:2] == aad_pkg::OFS_FDATA[aad_pkg::WBAW-1:2];

  // software may not write instr, acc, status or file data while an instruction runs; faddr stays writable
  assign instrWr = wbWr && selInstr && (|wb_sel_i[1:0]) && !busy;
  assign accWr = wbWr && selAcc && wb_sel_i[0] && !busy;
  assign statusWr = wbWr && selStatus && wb_sel_i[0] && !busy;
  assign fAddrWr = wbWr && selFAddr && wb_sel_i[0];
  assign fDataWr = wbWr && selFData && wb_sel_i[0] && !busy;

  assign instrWord = {wb_sel_i[1] ? wb_dat_i[aad_pkg::IW-1:8] : instrReg[aad_pkg::IW-1:8],
                      wb_sel_i[0] ? wb_dat_i[7:0] : instrReg[7:0]};

  // addresses past the array read as zero
  assign fileRd = (int'(fAddrReg) < FDEPTH) ? fileMem[fAddrReg] : '0;

  always_comb
  begin
    statusWord = '0;
    statusWord[aad_pkg::ST_C] = flags.c;
    statusWord[aad_pkg::ST_DC] = flags.dc;
    statusWord[aad_pkg::ST_Z] = flags.z;
    statusWord[aad_pkg::ST_BUSY] = busy;
    statusWord[aad_pkg::ST_UNSUP] = unsup;
  end

  assign rdData = selInstr ? {{(aad_pkg::WBDW - aad_pkg::IW){1'b0}}, instrReg} :
                  selAcc ? {{(aad_pkg::WBDW - aad_pkg::DW){1'b0}}, acc} :
                  selStatus ? statusWord :
                  selFAddr ? {{(aad_pkg::WBDW - aad_pkg::FAW){1'b0}}, fAddrReg} :
                  selFData ? {{(aad_pkg::WBDW - aad_pkg::DW){1'b0}}, fileRd} :
                  '0;

  // ------------------------------------------------------------
  // wishbone answer
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ackReg <= 1'b0;
    else
      ackReg <= wbAct && !ackReg;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      datReg <= '0;
    else if (wbAct && !ackReg)
      datReg <= rdData;
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;

  // ------------------------------------------------------------
  // quarter phases
  // ------------------------------------------------------------
  aad_pkg::aad_phase_e phase;
  logic qTick;
  logic q1Tick;
  logic q2Tick;
  logic q3Tick;
  logic q4Tick;

  aad_qphase #(
    .QDIV(QDIV)
  ) u_qphase (
    .clk(clk),
    .rstn(rstn),
    .start(instrWr),
    .phase(phase),
    .qTick(qTick)
  );

  assign busy = phase != aad_pkg::PH_IDLE;
  assign q1Tick = qTick && (phase == aad_pkg::PH_Q1);
  assign q2Tick = qTick && (phase == aad_pkg::PH_Q2);
  assign q3Tick = qTick && (phase == aad_pkg::PH_Q3);
  assign q4Tick = qTick && (phase == aad_pkg::PH_Q4);
  assign done = q4Tick;

  // ------------------------------------------------------------
  // instruction decode
  // ------------------------------------------------------------
  logic isAddL;
  logic isAndL;
  logic isAddR;
  logic isAndR;
  aad_pkg::aad_op_e decOp;
  aad_pkg::aad_instr_s decNow;

  assign isAddL = instrReg[aad_pkg::IW-1:aad_pkg::IW-5] == aad_pkg::OPC_ADDL;
  assign isAndL = instrReg[aad_pkg::IW-1:aad_pkg::IW-6] == aad_pkg::OPC_ANDL;
  assign isAddR = instrReg[aad_pkg::IW-1:aad_pkg::IW-6] == aad_pkg::OPC_ADDR;
  assign isAndR = instrReg[aad_pkg::IW-1:aad_pkg::IW-6] == aad_pkg::OPC_ANDR;

  assign decOp = isAddL ? aad_pkg::OP_ADDL :
                 isAndL ? aad_pkg::OP_ANDL :
                 isAddR ? aad_pkg::OP_ADDR :
                 isAndR ? aad_pkg::OP_ANDR :
                 aad_pkg::OP_NOP;

  // literal forms always target the accumulator
  assign decNow = '{op: decOp,
                    toReg: (isAddR || isAndR) && instrReg[aad_pkg::DEST_BIT],
                    fAddr: instrReg[aad_pkg::FAW-1:0],
                    lit: instrReg[aad_pkg::DW-1:0]};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      instrReg <= aad_pkg::INSTR_RST;
    else if (instrWr)
      instrReg <= instrWord;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dec <= '0;
    else if (q1Tick)
      dec <= decNow;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      unsup <= 1'b0;
    else if (q1Tick)
      unsup <= decOp == aad_pkg::OP_NOP;
  end

  // ------------------------------------------------------------
  // operand fetch and compute
  // ------------------------------------------------------------
  logic litOp;
  logic [aad_pkg::DW-1:0] regRd;
  logic [aad_pkg::DW-1:0] aluRes;
  aad_pkg::aad_flags_s aluFlags;
  logic aluUpdCarry;
  logic aluUpdZero;

  assign litOp = (dec.op == aad_pkg::OP_ADDL) || (dec.op == aad_pkg::OP_ANDL);
  assign regRd = (int'(dec.fAddr) < FDEPTH) ? fileMem[dec.fAddr] : '0;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      operand <= '0;
    else if (q2Tick)
      operand <= litOp ? dec.lit : regRd;
  end

  aad_alu u_alu (
    .op(dec.op),
    .acc(acc),
    .operand(operand),
    .result(aluRes),
    .flags(aluFlags),
    .updCarry(aluUpdCarry),
    .updZero(aluUpdZero)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result <= '0;
      resFlags <= '0;
      resUpdCarry <= 1'b0;
      resUpdZero <= 1'b0;
    end
    else if (q3Tick)
    begin
      result <= aluRes;
      resFlags <= aluFlags;
      resUpdCarry <= aluUpdCarry;
      resUpdZero <= aluUpdZero;
    end
  end

  // ------------------------------------------------------------
  // write back
  // ------------------------------------------------------------
  logic wrAcc;
  logic wrFile;

  assign wrAcc = q4Tick && (dec.op != aad_pkg::OP_NOP) && !dec.toReg;
  assign wrFile = q4Tick && (dec.op != aad_pkg::OP_NOP) && dec.toReg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      acc <= aad_pkg::ACC_RST;
    else if (wrAcc)
      acc <= result;
    else if (accWr)
      acc <= wb_dat_i[aad_pkg::DW-1:0];
  end

  // no reset: file registers power up undefined, as ram does
  always_ff @(posedge clk)
  begin
    if (wrFile && int'(dec.fAddr) < FDEPTH)
      fileMem[dec.fAddr] <= result;
    else if (fDataWr && int'(fAddrReg) < FDEPTH)
      fileMem[fAddrReg] <= wb_dat_i[aad_pkg::DW-1:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fAddrReg <= aad_pkg::FADDR_RST;
    else if (fAddrWr)
      fAddrReg <= wb_dat_i[aad_pkg::FAW-1:0];
  end

  // and forms leave carry and digit carry untouched
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags <= '0;
    else if (q4Tick && resUpdZero)
    begin
      flags.z <= resFlags.z;
      if (resUpdCarry)
      begin
        flags.c <= resFlags.c;
        flags.dc <= resFlags.dc;
      end
    end
    else if (statusWr)
    begin
      flags.c <= wb_dat_i[aad_pkg::ST_C];
      flags.dc <= wb_dat_i[aad_pkg::ST_DC];
      flags.z <= wb_dat_i[aad_pkg::ST_Z];
    end
  end

endmodule

// >>> aad_datapath_checker.sv
// concurrent checks on the ports of the add and accumulator datapath
module aad_datapath_checker #(
  parameter int QDIV = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [aad_pkg::WBAW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [aad_pkg::WBDW-1:0] wb_dat_i,
  input wire logic [aad_pkg::WBDW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic busy,
  input wire logic done
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // phase lengths below assume one clock per quarter
  wire logic oneQ = (QDIV == 1);
  wire logic instrWr = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[1:0] != 2'h0;
  wire logic unmapRd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h04;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  start_busy_a: assert property (instrWr && !busy |=> busy)
    else $error("instruction write did not start execution");
  busy_span_a: assert property (oneQ && $rose(busy) |-> busy [*4] ##1 !busy)
    else $error("instruction cycle not four quarters long");
  done_q4_a: assert property (oneQ && $rose(busy) |-> !done [*3] ##1 done)
    else $error("done not in the fourth quarter");
  done_pulse_a: assert property (done |-> busy ##1 !done)
    else $error("done not a single pulse inside busy");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  unmapped_zero_a: assert property (unmapRd |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  done_end_a: assert property (done |=> !busy)
    else $error("busy held after done");

  cover_start_c: cover property (instrWr && !busy);
  cover_done_c: cover property (done);
  cover_unmap_c: cover property (unmapRd);
endmodule

bind aad_datapath aad_datapath_checker #(.QDIV(QDIV)) chk_u (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy), .done(done));

// >>> add_and_accumulator_datapath_bench.sv
// self-checking bench of the add and accumulator datapath
module add_and_accumulator_datapath_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic busy;
  logic done;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] tmp;
  int doneCnt = 0;
  int busyCnt = 0;

  always #4 clk = ~clk;

  // counts taken from the pins, independent of the status register
  always @(posedge clk)
  begin
    if (done === 1'b1)
      doneCnt <= doneCnt + 1;
    if (busy === 1'b1)
      busyCnt <= busyCnt + 1;
  end

  aad_datapath #(.QDIV(1), .FDEPTH(128)) dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .busy(busy), .done(done));

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  // request held until ack is sampled at a rising edge; data taken there
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d, 4'h3, tmp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wbx(1'b0, a, 32'h0, 4'hf, q);
  endtask

  // busy is polled, wait_idle never assumes the instruction length; run_case checks for four busy cycles
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h100;
    for (int i = 0; i < 20 && s[aad_pkg::ST_BUSY] !== 1'b0; i++)
      rd(aad_pkg::OFS_STATUS, s);
    chk("busy", {31'h0, s[aad_pkg::ST_BUSY]}, 32'h0);
  endtask

  // loads acc, status and file word 0x04, executes, then reads everything back
  task automatic run_case(input logic [7:0] a0, input logic [2:0] s0, input logic [7:0] f0, input logic [13:0] ins,
                          input logic [7:0] ea, input logic [7:0] ef, input logic [2:0] es);
    logic [31:0] q;
    int d0;
    int b0;
    wr(aad_pkg::OFS_FADDR, 32'h04);
    wr(aad_pkg::OFS_FDATA, {24'h0, f0});
    wr(aad_pkg::OFS_ACC, {24'h0, a0});
    wr(aad_pkg::OFS_STATUS, {29'h0, s0});
    d0 = doneCnt;
    b0 = busyCnt;
    wr(aad_pkg::OFS_INSTR, {18'h0, ins});
    wait_idle();
    chk("done pulses", 32'(doneCnt - d0), 32'h1);
    chk("busy cycles", 32'(busyCnt - b0), 32'h4);
    rd(aad_pkg::OFS_ACC, q);
    chk("acc", q, {24'h0, ea});
    rd(aad_pkg::OFS_FDATA, q);
    chk("file", q, {24'h0, ef});
    rd(aad_pkg::OFS_STATUS, q);
    chk("flags", {22'h0, q[9:0]}, {29'h0, es});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    rd(aad_pkg::OFS_ACC, q);
    chk("acc reset", q, 32'h0);
    rd(aad_pkg::OFS_STATUS, q);
    chk("status reset", q, 32'h0);
    rd(aad_pkg::OFS_INSTR, q);
    chk("instr reset", q, 32'h0);
    rd(aad_pkg::OFS_FADDR, q);
    chk("faddr reset", q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_add_lit();
    run_case(8'h10, 3'h0, 8'h00, 14'h3e15, 8'h25, 8'h00, 3'h0);
    run_case(8'hf8, 3'h0, 8'h00, 14'h3f0f, 8'h07, 8'h00, 3'h3);
    run_case(8'h01, 3'h0, 8'h00, 14'h3eff, 8'h00, 8'h00, 3'h7);
    $display("test add literal done");
  endtask

  task automatic t_and_lit();
    run_case(8'ha3, 3'h3, 8'h00, 14'h395f, 8'h03, 8'h00, 3'h3);
    run_case(8'ha3, 3'h0, 8'h00, 14'h3900, 8'h00, 8'h00, 3'h4);
    $display("test and literal done");
  endtask

  task automatic t_add_reg();
    run_case(8'h17, 3'h0, 8'hc2, 14'h0704, 8'hd9, 8'hc2, 3'h0);
    run_case(8'hd9, 3'h0, 8'hc2, 14'h0784, 8'hd9, 8'h9b, 3'h1);
    run_case(8'h08, 3'h0, 8'hf8, 14'h0704, 8'h00, 8'hf8, 3'h7);
    $display("test add register done");
  endtask

  task automatic t_and_reg();
    run_case(8'h17, 3'h3, 8'hc2, 14'h0584, 8'h17, 8'h02, 3'h3);
    run_case(8'h17, 3'h0, 8'h00, 14'h0504, 8'h00, 8'h00, 3'h4);
    $display("test and register done");
  endtask

  task automatic t_refuse();
    logic [31:0] q;
    wr(aad_pkg::OFS_ACC, 32'h10);
    wr(aad_pkg::OFS_INSTR, 32'h3e01);
    wr(aad_pkg::OFS_ACC, 32'hff);
    wait_idle();
    rd(aad_pkg::OFS_ACC, q);
    chk("acc busy write", q, 32'h11);
    rd(8'h40, q);
    chk("unmapped", q, 32'h0);
    wr(aad_pkg::OFS_INSTR, 32'h3a55);
    wait_idle();
    rd(aad_pkg::OFS_ACC, q);
    chk("acc unsupported", q, 32'h11);
    rd(aad_pkg::OFS_STATUS, q);
    chk("unsup", {31'h0, q[aad_pkg::ST_UNSUP]}, 32'h1);
    rd(aad_pkg::OFS_INSTR, q);
    chk("instr readback", q, 32'h3a55);
    rd(aad_pkg::OFS_FADDR, q);
    chk("faddr readback", q, 32'h04);
    $display("test refusals done");
  endtask

  // a reset in mid-run must clear acc, flags and the unsupported mark
  task automatic t_rereset();
    logic [31:0] q;
    wr(aad_pkg::OFS_ACC, 32'h5a);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(aad_pkg::OFS_ACC, q);
    chk("acc rereset", q, 32'h0);
    rd(aad_pkg::OFS_STATUS, q);
    chk("status rereset", q, 32'h0);
    $display("test mid-run reset done");
  endtask

  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_add_lit();
    t_and_lit();
    t_add_reg();
    t_and_reg();
    t_refuse();
    t_rereset();
    results();
  end

  // whole run needs a few hundred cycles
  initial
  begin
    #200000;
    fails++;
    results();
  end
endmodule
